//--- hw/coa_core.sv
// Operand addressing sequencer: fetches operands, walks memory accesses.
// Assumes fetch and memory ports answer with a one-cycle acknowledge.
`timescale 1ns/10ps
module coa_core
  import coa_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  // Instruction start
  input wire logic START_IN,
  input wire logic [3:0] MODE_IN,
  input wire logic [2:0] OP_IN,
  input wire logic [1:0] REG_SEL_IN,
  input wire logic SPACE_IN,
  // Operand byte fetch
  output logic FETCH_REQ_OUT,
  input wire logic FETCH_ACK_IN,
  input wire logic [7:0] FETCH_DATA_IN,
  // Data RAM and register space
  output logic MEM_REQ_OUT,
  output logic MEM_WE_OUT,
  output logic MEM_REG_OUT,
  output logic MEM_BANK_OUT,
  output logic [7:0] MEM_ADDR_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  input wire logic MEM_ACK_IN,
  input wire logic [7:0] MEM_RDATA_IN,
  // Status
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic ILLEGAL_OUT,
  output logic [1:0] LEN_OUT,
  // Core registers
  output logic [7:0] ACC_OUT,
  output logic [7:0] INDEX_OUT,
  output logic [7:0] STACK_OUT,
  output logic [7:0] FLAGS_OUT
);

  typedef struct packed {
    coa_state_type st;
    coa_mode_type mode;
    coa_op_type op;
    logic [1:0] rsel;
    logic space;
    logic [7:0] op1;
    logic [7:0] ptr;
    logic [7:0] src;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] sp;
    logic [7:0] f;
    logic [7:0] maddr;
    logic [7:0] mwdata;
    logic mreq;
    logic mwe;
    logic mreg;
    logic mbank;
    logic freq;
    logic done;
    logic illegal;
    logic busy;
    logic [1:0] len;
  } coa_core_type;

  localparam coa_core_type CORE_RESET = '{st: ST_IDLE, mode: M_SRC_IMM,
    op: OP_MOVE, f: RESET_FLAGS, default: '0};

  coa_core_type s_q;
  coa_core_type s_d;
  coa_addr_if ai ();

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] alu(input coa_op_type op,
                                     input logic [7:0] a,
                                     input logic [7:0] b);
    unique case (op)
      OP_ADD: alu = 8'(a + b);
      OP_SUB: alu = 8'(a - b);
      OP_AND: alu = a & b;
      OP_OR: alu = a | b;
      OP_XOR: alu = a ^ b;
      default: alu = b;
    endcase
  endfunction : alu

  function automatic logic [7:0] get(input coa_core_type t,
                                     input logic [1:0] r);
    unique case (r)
      R_ACC: get = t.a;
      R_INDEX: get = t.x;
      R_STACK: get = t.sp;
      default: get = t.f;
    endcase
  endfunction : get

  function automatic coa_core_type put(input coa_core_type t,
                                       input logic [1:0] r,
                                       input logic [7:0] v);
    coa_core_type u;
    u = t;
    unique case (r)
      R_ACC: u.a = v;
      R_INDEX: u.x = v;
      R_STACK: u.sp = v;
      default: u.f = v;
    endcase
    put = u;
  endfunction : put

  // Bank is sampled per access, so a flags write takes effect next access
  function automatic coa_core_type issue(input coa_core_type t,
                                         input logic [7:0] addr,
                                         input logic we,
                                         input logic [7:0] wd,
                                         input logic rs);
    coa_core_type u;
    u = t;
    u.mreq = 1'b1;
    u.mwe = we;
    u.maddr = addr;
    u.mwdata = wd;
    u.mreg = rs;
    u.mbank = rs & t.f[FLAG_BANK_BIT];
    issue = u;
  endfunction : issue

  function automatic logic three_byte(input coa_mode_type m);
    three_byte = (m == M_DST_DIR_IMM) || (m == M_DST_IDX_IMM) ||
                 (m == M_DIR_DIR);
  endfunction : three_byte

  // ----------------------------------------------------------------------
  // Decode of the request and operands in hand
  // ----------------------------------------------------------------------
  coa_mode_type in_mode;
  coa_op_type in_op;
  logic bad;
  logic [7:0] o1;
  logic [7:0] o2;
  logic opnd_ready;

  always_comb begin
    in_mode = coa_mode_type'(MODE_IN);
    in_op = coa_op_type'(OP_IN);
    bad = (MODE_IN > M_IND_STORE) || (OP_IN > OP_IND_MOVE);
    if (in_mode == M_DIR_DIR && in_op != OP_MOVE) begin
      bad = 1'b1;
    end
    if ((in_mode == M_IND_LOAD || in_mode == M_IND_STORE) !=
        (in_op == OP_IND_MOVE)) begin
      bad = 1'b1;
    end
    o1 = (s_q.st == ST_FETCH1) ? FETCH_DATA_IN : s_q.op1;
    o2 = FETCH_DATA_IN;
    opnd_ready = FETCH_ACK_IN &&
                 ((s_q.st == ST_FETCH1 && !three_byte(s_q.mode)) ||
                  s_q.st == ST_FETCH2);
  end

  assign ai.oper = o1;
  assign ai.index = s_q.x;
  assign ai.use_index = (s_q.mode == M_SRC_IDX) ||
                        (s_q.mode == M_DST_IDX) ||
                        (s_q.mode == M_DST_IDX_IMM);
  assign ai.ptr = s_q.ptr;

  coa_agen u_agen (
    .ai (ai)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.illegal = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (START_IN) begin
          s_d.mode = in_mode;
          s_d.op = in_op;
          s_d.rsel = REG_SEL_IN;
          s_d.space = SPACE_IN;
          if (bad) begin
            s_d.st = ST_DONE;
            s_d.done = 1'b1;
            s_d.illegal = 1'b1;
            s_d.len = LEN_ONE;
          end else begin
            s_d.st = ST_FETCH1;
            s_d.freq = 1'b1;
            s_d.len = three_byte(in_mode) ? LEN_THREE : LEN_TWO;
          end
        end
      end
      ST_FETCH1, ST_FETCH2: begin
        if (FETCH_ACK_IN && s_q.st == ST_FETCH1) begin
          s_d.op1 = FETCH_DATA_IN;
          s_d.st = ST_FETCH2;
        end
        if (opnd_ready) begin
          s_d.freq = 1'b0;
          s_d.src = three_byte(s_q.mode) ? o2 :
                    (s_q.mode == M_DST_IDX) ? s_q.a : get(s_q, s_q.rsel);
          unique case (s_q.mode)
            M_SRC_IMM: begin
              s_d = put(s_d, s_q.rsel,
                        alu(s_q.op, get(s_q, s_q.rsel), o1));
              s_d.st = ST_DONE;
              s_d.done = 1'b1;
            end
            M_SRC_DIR, M_SRC_IDX: begin
              s_d = issue(s_d, ai.eff, 1'b0, RESET_ZERO,
                          s_q.space);
              s_d.st = ST_RD_SRC;
            end
            M_DIR_DIR: begin
              s_d = issue(s_d, o2, 1'b0, RESET_ZERO, 1'b0);
              s_d.st = ST_RD_SRC;
            end
            M_IND_LOAD, M_IND_STORE: begin
              s_d = issue(s_d, o1, 1'b0, RESET_ZERO, 1'b0);
              s_d.st = ST_RD_PTR;
            end
            default: begin
              if (s_q.op == OP_MOVE) begin
                s_d = issue(s_d, ai.eff, 1'b1, s_d.src,
                            s_q.space);
                s_d.st = ST_WR_DST;
              end else begin
                s_d = issue(s_d, ai.eff, 1'b0, RESET_ZERO,
                            s_q.space);
                s_d.st = ST_RD_SRC;
              end
            end
          endcase
        end
      end
      ST_RD_PTR: begin
        if (MEM_ACK_IN) begin
          s_d.ptr = MEM_RDATA_IN;
          if (s_q.mode == M_IND_LOAD) begin
            s_d = issue(s_d, MEM_RDATA_IN, 1'b0, RESET_ZERO, 1'b0);
            s_d.st = ST_RD_SRC;
          end else begin
            s_d = issue(s_d, MEM_RDATA_IN, 1'b1, s_q.a, 1'b0);
            s_d.st = ST_WR_DST;
          end
        end
      end
      ST_RD_SRC: begin
        if (MEM_ACK_IN) begin
          s_d.mreq = 1'b0;
          unique case (s_q.mode)
            M_SRC_DIR, M_SRC_IDX: begin
              s_d = put(s_d, s_q.rsel,
                        alu(s_q.op, get(s_q, s_q.rsel), MEM_RDATA_IN));
              s_d.st = ST_DONE;
              s_d.done = 1'b1;
            end
            M_IND_LOAD: begin
              s_d.a = MEM_RDATA_IN;
              s_d = issue(s_d, s_q.op1, 1'b1, ai.ptr_inc, 1'b0);
              s_d.st = ST_WR_PTR;
            end
            M_DIR_DIR: begin
              s_d = issue(s_d, s_q.op1, 1'b1, MEM_RDATA_IN, 1'b0);
              s_d.st = ST_WR_DST;
            end
            default: begin
              // Result goes back to memory; A is left as it was
              s_d = issue(s_d, s_q.maddr, 1'b1,
                          alu(s_q.op, MEM_RDATA_IN, s_q.src),
                          s_q.mreg);
              s_d.st = ST_WR_DST;
            end
          endcase
        end
      end
      ST_WR_DST: begin
        if (MEM_ACK_IN) begin
          s_d.mreq = 1'b0;
          if (s_q.mode == M_IND_STORE) begin
            s_d = issue(s_d, s_q.op1, 1'b1, ai.ptr_inc, 1'b0);
            s_d.st = ST_WR_PTR;
          end else begin
            s_d.st = ST_DONE;
            s_d.done = 1'b1;
          end
        end
      end
      ST_WR_PTR: begin
        if (MEM_ACK_IN) begin
          s_d.mreq = 1'b0;
          s_d.st = ST_DONE;
          s_d.done = 1'b1;
        end
      end
      ST_DONE: begin
        s_d.st = ST_IDLE;
      end
    endcase
    s_d.busy = (s_d.st != ST_IDLE);
  end

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s_q <= CORE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign FETCH_REQ_OUT = s_q.freq;
  assign MEM_REQ_OUT = s_q.mreq;
  assign MEM_WE_OUT = s_q.mwe;
  assign MEM_REG_OUT = s_q.mreg;
  assign MEM_BANK_OUT = s_q.mbank;
  assign MEM_ADDR_OUT = s_q.maddr;
  assign MEM_WDATA_OUT = s_q.mwdata;
  assign BUSY_OUT = s_q.busy;
  assign DONE_OUT = s_q.done;
  assign ILLEGAL_OUT = s_q.illegal;
  assign LEN_OUT = s_q.len;
  assign ACC_OUT = s_q.a;
  assign INDEX_OUT = s_q.x;
  assign STACK_OUT = s_q.sp;
  assign FLAGS_OUT = s_q.f;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);

  chk_imm_length: assert property (
    (DONE_OUT && !ILLEGAL_OUT && s_q.mode == M_SRC_IMM) |-> LEN_OUT == LEN_TWO)
    else $error("immediate form length not two");
  chk_srcdir_addr: assert property (
    (MEM_REQ_OUT && s_q.st == ST_RD_SRC && s_q.mode == M_SRC_DIR)
      |-> MEM_ADDR_OUT == s_q.op1 && !MEM_WE_OUT)
    else $error("direct source address wrong");
  chk_srcidx_addr: assert property (
    (MEM_REQ_OUT && s_q.st == ST_RD_SRC && s_q.mode == M_SRC_IDX)
      |-> MEM_ADDR_OUT == coa_wrap_add(s_q.op1, s_q.x))
    else $error("indexed source address wrong");
  chk_dstdir_addr: assert property (
    (MEM_REQ_OUT && MEM_WE_OUT && s_q.mode == M_DST_DIR)
      |-> MEM_ADDR_OUT == s_q.op1)
    else $error("direct destination address wrong");
  chk_acc_kept: assert property (
    (BUSY_OUT && s_q.mode inside {M_DST_DIR, M_DST_IDX, M_DST_DIR_IMM,
      M_DST_IDX_IMM}) |=> $stable(ACC_OUT))
    else $error("accumulator changed on memory result");
  chk_dstidx_addr: assert property (
    (MEM_REQ_OUT && MEM_WE_OUT && s_q.mode == M_DST_IDX_IMM)
      |-> MEM_ADDR_OUT == coa_wrap_add(s_q.op1, s_q.x))
    else $error("indexed immediate destination address wrong");
  chk_three_length: assert property (
    (DONE_OUT && !ILLEGAL_OUT && s_q.mode == M_DST_DIR_IMM)
      |-> LEN_OUT == LEN_THREE)
    else $error("three byte form length wrong");
  chk_memmem_legal: assert property (
    (!BUSY_OUT && START_IN && MODE_IN == M_DIR_DIR && OP_IN != OP_MOVE)
      |=> ILLEGAL_OUT && DONE_OUT && !FETCH_REQ_OUT)
    else $error("memory to memory accepted for non move");
  chk_ptr_inc: assert property (
    (MEM_REQ_OUT && s_q.st == ST_WR_PTR)
      |-> MEM_WDATA_OUT == coa_wrap_add(s_q.ptr, PTR_STEP)
        && MEM_ADDR_OUT == s_q.op1)
    else $error("pointer write back wrong");
  chk_ind_legal: assert property (
    (!BUSY_OUT && START_IN && MODE_IN inside {M_IND_LOAD, M_IND_STORE}
      && OP_IN != OP_IND_MOVE) |=> ILLEGAL_OUT ##1 !BUSY_OUT)
    else $error("indirect form accepted for other operation");
  chk_bank_sel: assert property (
    (MEM_REQ_OUT && MEM_REG_OUT && !$changed(FLAGS_OUT))
      |-> MEM_BANK_OUT == FLAGS_OUT[FLAG_BANK_BIT])
    else $error("register bank does not follow flags");
  chk_fetch_first: assert property (
    (!BUSY_OUT && START_IN && !bad) |=> FETCH_REQ_OUT && s_q.st == ST_FETCH1)
    else $error("operand fetch did not follow start");

endmodule : coa_core

//--- hw/coa_pkg.sv
// Constants and types of the operand addressing block.
// Assumes one 10 MHz clock and an active-low asynchronous reset.
//
// Functional notes
// - Immediate operand; named A, F, SP or X is source and result.
// - Direct source: operand addresses RAM or registers; result to A or X.
// - Indexed source: operand plus X addresses source; result to A or X.
// - Result to operand address; source A or X; location is second source.
// - Direct-destination arithmetic to memory leaves A unchanged.
// - Indexed destination: X plus operand addresses result; A is source.
// - Direct destination plus immediate: first byte address, second value.
// - Indexed destination plus immediate: X plus first byte is address.
// - Memory-to-memory form only for the plain move; three bytes long.
// - Indirect load: read pointer, load A from it, write pointer plus one.
// - Indirect store: read pointer, write A there, write pointer plus one.
// - Indirect forms are legal only on indirect move; otherwise illegal.
// - Register-space accesses use the bank picked by the flags bank bit.
package coa_pkg;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam logic [7:0] RESET_FLAGS = 8'h02;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam int FLAG_BANK_BIT = 4;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    M_SRC_IMM = 4'h0,
    M_SRC_DIR = 4'h1,
    M_SRC_IDX = 4'h2,
    M_DST_DIR = 4'h3,
    M_DST_IDX = 4'h4,
    M_DST_DIR_IMM = 4'h5,
    M_DST_IDX_IMM = 4'h6,
    M_DIR_DIR = 4'h7,
    M_IND_LOAD = 4'h8,
    M_IND_STORE = 4'h9
  } coa_mode_type;

  typedef enum logic [2:0] {
    OP_MOVE = 3'h0,
    OP_ADD = 3'h1,
    OP_SUB = 3'h2,
    OP_AND = 3'h3,
    OP_OR = 3'h4,
    OP_XOR = 3'h5,
    OP_IND_MOVE = 3'h6
  } coa_op_type;

  typedef enum logic [1:0] {
    R_ACC = 2'h0,
    R_INDEX = 2'h1,
    R_STACK = 2'h2,
    R_FLAGS = 2'h3
  } coa_reg_type;

  // Gray codes along fetch, pointer, read, write, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH1 = 3'h1,
    ST_FETCH2 = 3'h3,
    ST_RD_PTR = 3'h2,
    ST_RD_SRC = 3'h6,
    ST_WR_DST = 3'h7,
    ST_WR_PTR = 3'h5,
    ST_DONE = 3'h4
  } coa_state_type;

  // ----------------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------------
  function automatic logic [7:0] coa_wrap_add(input logic [7:0] a,
                                              input logic [7:0] b);
    coa_wrap_add = 8'(a + b);
  endfunction : coa_wrap_add

endpackage : coa_pkg

//--- hw/coa_addr_if.sv
// Carrier between the sequencer and its address generator.
// Assumes purely combinational use inside one clock domain.
`timescale 1ns/10ps
interface coa_addr_if;
  logic [7:0] oper;
  logic [7:0] index;
  logic use_index;
  logic [7:0] ptr;
  logic [7:0] eff;
  logic [7:0] ptr_inc;

  modport core (output oper, output index, output use_index, output ptr,
                input eff, input ptr_inc);
  modport agen (input oper, input index, input use_index, input ptr,
                output eff, output ptr_inc);
endinterface : coa_addr_if

//--- hw/coa_agen.sv
// Effective address and pointer increment for the operand sequencer.
// Assumes inputs are settled within the cycle; no state is kept here.
`timescale 1ns/10ps
module coa_agen
  import coa_pkg::*;
(
  coa_addr_if.agen ai
);

  // ----------------------------------------------------------------------
  // Address arithmetic, wrapping inside the 8-bit space
  // ----------------------------------------------------------------------
  assign ai.eff = ai.use_index ? coa_wrap_add(ai.oper, ai.index)
                               : ai.oper;
  assign ai.ptr_inc = coa_wrap_add(ai.ptr, PTR_STEP);

endmodule : coa_agen

//--- sim/coa_mem_model.sv
// Behavioural data RAM and two-bank register space on the memory port.
// Assumes the requester holds its request until the one-cycle acknowledge.
`timescale 1ns/10ps
module coa_mem_model (
  // Clock and pacing
  input wire logic clk_in,
  input wire logic slow_in,
  // Memory request
  input wire logic req_in,
  input wire logic we_in,
  input wire logic reg_in,
  input wire logic bank_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  // Answer
  output logic ack_out,
  output logic [7:0] rdata_out
);
  logic [7:0] ram [256];
  logic [7:0] rsp [2][256];
  logic [1:0] cnt;

  initial begin
    ack_out = 1'b0;
    rdata_out = 8'h00;
    cnt = 2'h0;
  end

  // --------------------------------------------------------------------
  // Access engine
  // --------------------------------------------------------------------
  // Read data toggles outside a read ack cycle so stale data never matches
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      if (slow_in && cnt != 2'h3) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt <= 2'h0;
        ack_out <= 1'b1;
        if (we_in && reg_in) begin
          rsp[bank_in][addr_in] <= wdata_in;
        end else if (we_in) begin
          ram[addr_in] <= wdata_in;
        end else begin
          rdata_out <= reg_in ? rsp[bank_in][addr_in] : ram[addr_in];
        end
      end
    end
  end
endmodule : coa_mem_model

//--- sim/cpu_operand_addressing_tb.sv
// Self-checking bench of the operand addressing sequencer.
// Assumes coa_pkg and the memory model are compiled first.
`timescale 1ns/10ps
module cpu_operand_addressing_tb;
  import coa_pkg::*;
  typedef struct packed {
    logic ill;
    logic [1:0] len;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] sp;
    logic [7:0] f;
  } coa_note_type;

  logic mclk = 1'b0, resetn = 1'b0, start = 1'b0, space = 1'b0;
  logic [3:0] mode = 4'h0;
  logic [2:0] op = 3'h0;
  logic [1:0] rsel = 2'h0, len;
  logic fetch_req, fetch_ack = 1'b0, mem_ack, mem_slow = 1'b0;
  logic [7:0] fetch_data = 8'h00, mem_rdata, addr, wdata;
  logic mem_req, we, regsp, bank, busy, done, ill;
  logic [7:0] acc, idx, stk, flg, a, x, sp, f, v;
  logic [31:0] lfsr = 32'h0000_9468;
  logic [7:0] fq [$];
  coa_note_type expq [$];
  coa_note_type mon_n;
  int err_count = 0, num_checks = 0, mem_cnt = 0, c0;
  logic [3:0] bm [7] = '{4'h8, 4'h9, 4'h0, 4'h7, 4'hA, 4'hF, 4'h1};
  logic [2:0] bo [7] = '{3'h0, 3'h1, 3'h6, 3'h2, 3'h0, 3'h0, 3'h7};

  always #50 mclk = ~mclk;

  coa_core coa_core_i (.MCLK_IN(mclk), .RESETN_IN(resetn),
    .START_IN(start), .MODE_IN(mode), .OP_IN(op), .REG_SEL_IN(rsel),
    .SPACE_IN(space), .FETCH_REQ_OUT(fetch_req), .FETCH_ACK_IN(fetch_ack),
    .FETCH_DATA_IN(fetch_data), .MEM_REQ_OUT(mem_req), .MEM_WE_OUT(we),
    .MEM_REG_OUT(regsp), .MEM_BANK_OUT(bank), .MEM_ADDR_OUT(addr),
    .MEM_WDATA_OUT(wdata), .MEM_ACK_IN(mem_ack), .MEM_RDATA_IN(mem_rdata),
    .BUSY_OUT(busy), .DONE_OUT(done), .ILLEGAL_OUT(ill), .LEN_OUT(len),
    .ACC_OUT(acc), .INDEX_OUT(idx), .STACK_OUT(stk), .FLAGS_OUT(flg));

  coa_mem_model coa_mem_model_i (.clk_in(mclk), .slow_in(mem_slow),
    .req_in(mem_req), .we_in(we), .reg_in(regsp), .bank_in(bank),
    .addr_in(addr), .wdata_in(wdata), .ack_out(mem_ack),
    .rdata_out(mem_rdata));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction : lfsr_next

  function automatic logic [7:0] alu(input logic [2:0] o,
                                     input logic [7:0] d, s);
    case (o)
      3'h1: alu = d + s;
      3'h2: alu = d - s;
      3'h3: alu = d & s;
      3'h4: alu = d | s;
      3'h5: alu = d ^ s;
      default: alu = s;
    endcase
  endfunction : alu

  task automatic chk(input logic [7:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Notes the expected outcome, queues operand bytes and starts one
  task automatic run(input logic [3:0] m, input logic [2:0] o,
                     input logic [1:0] r, input logic s,
                     input logic [7:0] b1, b2, input logic bad);
    coa_note_type n;
    int k;
    n = '{bad, LEN_TWO, a, x, sp, f};
    if (bad) n.len = LEN_ONE;
    else if (m inside {M_DST_DIR_IMM, M_DST_IDX_IMM, M_DIR_DIR}) begin
      n.len = LEN_THREE;
    end
    if (!bad) fq.push_back(b1);
    if (n.len == LEN_THREE) fq.push_back(b2);
    expq.push_back(n);
    @(negedge mclk);
    {start, mode, op, rsel, space} <= {1'b1, m, o, r, s};
    @(negedge mclk);
    start <= 1'b0;
    k = 0;
    while (expq.size() > 0 && k < 60) begin
      @(negedge mclk);
      k++;
    end
    if (expq.size() > 0) begin
      err_count++;
      $display("Error at %0t: no completion", $time);
      expq.delete();
    end
  endtask : run

  // --------------------------------------------------------------------
  // Far-side stimulus and result monitor
  // --------------------------------------------------------------------
  // Operand bytes come after a random stall; idle data is noise
  always @(negedge mclk) begin
    lfsr = lfsr_next(lfsr);
    mem_slow <= lfsr[9];
    if (mem_req === 1'b1) mem_cnt++;
    if (fetch_req === 1'b1 && !fetch_ack && fq.size() > 0 && lfsr[8]) begin
      fetch_ack <= 1'b1;
      fetch_data <= fq.pop_front();
    end else begin
      fetch_ack <= 1'b0;
      fetch_data <= lfsr[7:0];
    end
  end

  always @(negedge mclk) begin
    if (done === 1'b1) begin
      num_checks++;
      if (expq.size() == 0) begin
        err_count++;
        $display("Error at %0t: unexpected completion", $time);
      end else begin
        mon_n = expq.pop_front();
        if ({ill, len, acc, idx, stk, flg} !== mon_n) begin
          err_count++;
          $display("Error at %0t: result %h expected %h", $time,
                   {ill, len, acc, idx, stk, flg}, mon_n);
        end
      end
    end
  end

  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    test_done;
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {a, x, sp, f} = {8'h00, 8'h00, 8'h00, 8'h02};
    repeat (5) @(negedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk(flg, 8'h02, "reset flags");
    chk({7'h00, busy}, 8'h00, "reset busy");
    for (int i = 0; i < 6; i++) begin
      v = lfsr[7:0];
      a = alu(3'(i), a, v);
      run(M_SRC_IMM, 3'(i), R_ACC, 1'b0, v, 8'h00, 1'b0);
    end
    x = lfsr[15:8];
    run(M_SRC_IMM, OP_MOVE, R_INDEX, 1'b0, x, 8'h00, 1'b0);
    sp = alu(OP_ADD, sp, 8'h41);
    run(M_SRC_IMM, OP_ADD, R_STACK, 1'b0, 8'h41, 8'h00, 1'b0);
    f = 8'h12;
    run(M_SRC_IMM, OP_OR, R_FLAGS, 1'b0, 8'h10, 8'h00, 1'b0);
    $display("Test immediate done");
    coa_mem_model_i.ram[8'h40] = 8'h5A;
    coa_mem_model_i.rsp[0][8'h08] = 8'h3C;
    coa_mem_model_i.rsp[1][8'h08] = 8'hC3;
    a = a + 8'h5A;
    run(M_SRC_DIR, OP_ADD, R_ACC, 1'b0, 8'h40, 8'h00, 1'b0);
    x = 8'hC3;
    run(M_SRC_DIR, OP_MOVE, R_INDEX, 1'b1, 8'h08, 8'h00, 1'b0);
    coa_mem_model_i.ram[8'h13] = 8'h21;
    a = a ^ 8'h21;
    run(M_SRC_IDX, OP_XOR, R_ACC, 1'b0, 8'h50, 8'h00, 1'b0);
    f = 8'h02;
    run(M_SRC_IMM, OP_AND, R_FLAGS, 1'b0, 8'hEF, 8'h00, 1'b0);
    $display("Test source modes done");
    coa_mem_model_i.ram[8'h07] = 8'h30;
    coa_mem_model_i.ram[8'h03] = 8'h10;
    coa_mem_model_i.ram[8'h20] = 8'hF5;
    run(M_DST_DIR, OP_ADD, R_ACC, 1'b0, 8'h07, 8'h00, 1'b0);
    chk(coa_mem_model_i.ram[8'h07], 8'h30 + a, "dst direct");
    run(M_DST_DIR, OP_MOVE, R_ACC, 1'b1, 8'h08, 8'h00, 1'b0);
    chk(coa_mem_model_i.rsp[0][8'h08], a, "dst reg bank0");
    run(M_DST_IDX, OP_SUB, R_ACC, 1'b0, 8'h40, 8'h00, 1'b0);
    chk(coa_mem_model_i.ram[8'h03], 8'h10 - a, "dst indexed");
    run(M_DST_DIR_IMM, OP_AND, R_ACC, 1'b0, 8'h20, 8'h0F, 1'b0);
    chk(coa_mem_model_i.ram[8'h20], 8'h05, "dst dir imm");
    run(M_DST_IDX_IMM, OP_MOVE, R_ACC, 1'b1, 8'h3D, 8'h77, 1'b0);
    chk(coa_mem_model_i.rsp[0][8'h00], 8'h77, "dst idx imm");
    coa_mem_model_i.ram[8'h08] = 8'h99;
    run(M_DIR_DIR, OP_MOVE, R_ACC, 1'b0, 8'h07, 8'h08, 1'b0);
    chk(coa_mem_model_i.ram[8'h07], 8'h99, "mem to mem");
    $display("Test destination modes done");
    coa_mem_model_i.ram[8'h30] = 8'hFF;
    coa_mem_model_i.ram[8'hFF] = 8'hAB;
    a = 8'hAB;
    run(M_IND_LOAD, OP_IND_MOVE, R_ACC, 1'b0, 8'h30, 8'h00, 1'b0);
    chk(coa_mem_model_i.ram[8'h30], 8'h00, "load pointer wrap");
    run(M_IND_STORE, OP_IND_MOVE, R_ACC, 1'b1, 8'h30, 8'h00, 1'b0);
    chk(coa_mem_model_i.ram[8'h00], 8'hAB, "indirect store");
    chk(coa_mem_model_i.ram[8'h30], 8'h01, "store pointer");
    run(M_DST_IDX_IMM, OP_ADD, R_ACC, 1'b0, 8'h3D, 8'h01, 1'b0);
    chk(coa_mem_model_i.ram[8'h00], 8'hAC, "dst idx imm add");
    $display("Test indirect done");
    c0 = mem_cnt;
    for (int i = 0; i < 7; i++) begin
      run(bm[i], bo[i], R_ACC, 1'b0, 8'h07, 8'h08, 1'b1);
    end
    chk(8'(mem_cnt - c0), 8'h00, "illegal accessed memory");
    chk(coa_mem_model_i.ram[8'h07], 8'h99, "illegal wrote");
    $display("Test illegal done");
    test_done;
  end
endmodule : cpu_operand_addressing_tb
